// File: rtl/brh_defs.vh
// timing counts and widths for the bcd readout handshake port
`ifndef BRH_DEFS_VH
`define BRH_DEFS_VH
`define BRH_CLK_MHZ 250
`define BRH_SET_MS 30
`define BRH_VALID_MS 40
`define BRH_RELEASE_MS 16
`define BRH_PERIOD_MS 64
`define BRH_SET_CYC (`BRH_SET_MS * `BRH_CLK_MHZ * 1000)
`define BRH_VALID_CYC (`BRH_VALID_MS * `BRH_CLK_MHZ * 1000)
`define BRH_RELEASE_CYC (`BRH_RELEASE_MS * `BRH_CLK_MHZ * 1000)
`define BRH_PERIOD_CYC (`BRH_PERIOD_MS * `BRH_CLK_MHZ * 1000)
`define BRH_DATA_W 24
`define BRH_FIFO_DEPTH 4
`define BRH_CNT_W 25
`endif

// File: rtl/brh_fifo.v
// small synchronous fifo carrying measurement words to the readout port
`timescale 1ns/1ps
module brh_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire full;
  wire empty;

  // extra pointer bit separates full from empty
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem[rd_ptr_r[AW-1:0]];

  // storage array, no reset needed
  always @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  // pointer update
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (in_valid_i && !full) begin
        wr_ptr_r <= wr_ptr_r + {{AW{1'b0}}, 1'b1};
      end
      if (out_ready_i && !empty) begin
        rd_ptr_r <= rd_ptr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // brh_fifo

// File: rtl/brh_readout.v
// bcd readout handshake port: request, hold, data lines and valid strobe
// Operation
// - data and valid appear on the same edge, about 30 ms after request
// - single shot: valid drops 40 ms later
// - data lines released 16 ms after valid drops
// - continuous request refreshes data every 64 ms
// - hold during update never blanks data lines
// - request and hold inputs are active low
`timescale 1ns/1ps
`include "brh_defs.vh"
module brh_readout #(
  parameter [24:0] SET_CYC = `BRH_SET_CYC,
  parameter [24:0] VALID_CYC = `BRH_VALID_CYC,
  parameter [24:0] RELEASE_CYC = `BRH_RELEASE_CYC,
  parameter [24:0] PERIOD_CYC = `BRH_PERIOD_CYC
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire request_n_i,
  input wire hold_n_i,
  input wire meas_valid_i,
  output wire meas_ready_o,
  input wire [`BRH_DATA_W-1:0] meas_data_i,
  output reg [`BRH_DATA_W-1:0] bcd_data_o,
  output reg data_valid_o
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SET = 2'd1;
  localparam [1:0] ST_VALID = 2'd2;
  localparam [1:0] ST_RELEASE = 2'd3;

  reg [1:0] req_sync_r;
  reg [1:0] hold_sync_r;
  reg req_prev_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [24:0] cnt_r;
  reg [24:0] cnt_nxt;
  reg [24:0] per_r;
  reg [`BRH_DATA_W-1:0] latest_r;
  wire req_on;
  wire hold_on;
  wire req_rise;
  wire fifo_valid;
  wire fifo_take;
  wire [`BRH_DATA_W-1:0] fifo_data;

  // terminal count test, shared by every timed phase
  function done;
    input [24:0] cnt;
    input [24:0] lim;
    begin
      done = (cnt >= lim - 25'h0000001);
    end
  endfunction

  // pins are asynchronous, two flops before use
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_sync_r <= 2'h0;
      hold_sync_r <= 2'h0;
      req_prev_r <= 1'b0;
    end else begin
      req_sync_r <= {req_sync_r[0], ~request_n_i};
      hold_sync_r <= {hold_sync_r[0], ~hold_n_i};
      req_prev_r <= req_sync_r[1];
    end
  end
  assign req_on = req_sync_r[1];
  assign hold_on = hold_sync_r[1];
  assign req_rise = req_on & ~req_prev_r;

  brh_fifo #(
    .WIDTH(`BRH_DATA_W),
    .DEPTH(`BRH_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(meas_valid_i),
    .in_ready_o(meas_ready_o),
    .in_data_i(meas_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_data)
  );
  // hold stalls draining, so the fifo backs up to the source
  assign fifo_take = ~hold_on;

  // newest measurement; frozen while hold is on
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latest_r <= {`BRH_DATA_W{1'b0}};
    end else if (fifo_valid && fifo_take) begin
      latest_r <= fifo_data;
    end
  end

  // sequencer next state
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 25'h0000001;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 25'h0000000;
        if (req_rise) begin
          state_nxt = ST_SET;
        end
      end
      ST_SET: begin
        if (done(cnt_r, SET_CYC)) begin
          state_nxt = ST_VALID;
          cnt_nxt = 25'h0000000;
        end
      end
      ST_VALID: begin
        // continuous mode keeps valid up while request stays on
        if (!req_on && done(cnt_r, VALID_CYC)) begin
          state_nxt = ST_RELEASE;
          cnt_nxt = 25'h0000000;
        end
      end
      ST_RELEASE: begin
        if (done(cnt_r, RELEASE_CYC)) begin
          state_nxt = ST_IDLE;
          cnt_nxt = 25'h0000000;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 25'h0000000;
      end
    endcase
  end

  // sequencer, refresh period counter and outputs
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 25'h0000000;
      per_r <= 25'h0000000;
      bcd_data_o <= {`BRH_DATA_W{1'b0}};
      data_valid_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      data_valid_o <= (state_nxt == ST_VALID);
      if (state_r == ST_SET && state_nxt == ST_VALID) begin
        bcd_data_o <= latest_r;
        per_r <= 25'h0000000;
      end else if (state_r == ST_VALID && req_on) begin
        // swap straight to the new word; never passes through zero
        if (done(per_r, PERIOD_CYC)) begin
          bcd_data_o <= latest_r;
          per_r <= 25'h0000000;
        end else begin
          per_r <= per_r + 25'h0000001;
        end
      end else if (state_r == ST_RELEASE && state_nxt == ST_IDLE) begin
        bcd_data_o <= {`BRH_DATA_W{1'b0}};
      end
    end
  end
endmodule // brh_readout

// File: verif/brh_readout_monitor.sv
// assertions on the bcd readout port
`timescale 1ns/1ps
module brh_readout_monitor (
  input wire clk_i,
  input wire reset_n_i,
  input wire request_n_i,
  input wire hold_n_i,
  input wire [23:0] bcd_data_o,
  input wire data_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // sync flops add a few cycles to the set time
  chk_set_after_request: assert property ($fell(request_n_i) && !data_valid_o &&
    bcd_data_o == 24'h0 |-> ##[11:16] data_valid_o) else $error("valid late");
  chk_valid_min_width: assert property ($fell(data_valid_o) |->
    $past(data_valid_o, 11)) else $error("valid short");
  chk_data_release: assert property ($fell(data_valid_o) |->
    ##[3:7] bcd_data_o == 24'h0) else $error("data kept");
  chk_valid_while_req: assert property (data_valid_o && !request_n_i |=>
    data_valid_o) else $error("valid dropped");
  chk_no_blank_gap: assert property (data_valid_o && $past(bcd_data_o) != 24'h0 |->
    bcd_data_o != 24'h0) else $error("data blanked");
  chk_drop_needs_release: assert property ($fell(data_valid_o) |->
    request_n_i) else $error("drop under request");
  chk_data_with_valid: assert property ($rose(bcd_data_o != 24'h0) |->
    data_valid_o) else $error("data without valid");
endmodule // brh_readout_monitor
bind brh_readout brh_readout_monitor MON (.clk_i, .reset_n_i, .request_n_i, .hold_n_i,
  .bcd_data_o, .data_valid_o);

// File: verif/brh_plc_model.sv
// controller model: active-low request pulse, data latched on valid
`timescale 1ns/1ps
module brh_plc_model (
  input wire clk_i,
  input wire start_i,
  input wire [7:0] len_i,
  input wire data_valid_i,
  input wire [23:0] bcd_data_i,
  output wire request_n_o,
  output logic [23:0] got_o
);
  logic [7:0] left_r = 8'h0;
  logic seen_r = 1'b0;
  // low means asserted, like a closed contact
  assign request_n_o = (left_r == 8'h0);
  // count the request down; sample data only on the valid rise
  always @(posedge clk_i) begin
    if (start_i) left_r <= len_i;
    else if (left_r != 8'h0) left_r <= left_r - 8'h1;
    seen_r <= data_valid_i;
    if (data_valid_i && !seen_r) got_o <= bcd_data_i;
  end
endmodule // brh_plc_model

// File: verif/tb_top.sv
// self-checking bench for the bcd readout port
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, reset_n_i = 0, hold_n_i = 1, meas_valid_i = 0, go = 0;
  logic [23:0] meas_data_i = 24'h0;
  logic [7:0] len = 8'h0;
  wire request_n_i, meas_ready_o, data_valid_o;
  wire [23:0] bcd_data_o, got;
  int n_fail = 0, num_checks = 0, n;
  always #2 clk_i = ~clk_i;
  // short counts keep the run brief
  brh_readout #(.SET_CYC(25'd10), .VALID_CYC(25'd12), .RELEASE_CYC(25'd5),
    .PERIOD_CYC(25'd20)) DUT (.clk_i, .reset_n_i, .request_n_i, .hold_n_i, .meas_valid_i,
    .meas_ready_o, .meas_data_i, .bcd_data_o, .data_valid_o);
  brh_plc_model PLC (.clk_i, .start_i(go), .len_i(len), .data_valid_i(data_valid_o),
    .bcd_data_i(bcd_data_o), .request_n_o(request_n_i), .got_o(got));
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // bounded wait on the strobe, n holds the cycles spent
  task until_v(input logic v);
    n = 0;
    while (data_valid_o !== v) begin
      tick(1);
      n++;
      if (n > 250) begin
        n_fail++;
        report_and_stop;
      end
    end
  endtask
  task feed(input logic [23:0] w);
    meas_data_i = w;
    meas_valid_i = 1;
    tick(1);
    meas_valid_i = 0;
  endtask
  task req(input logic [7:0] k);
    len = k;
    go = 1;
    tick(1);
    go = 0;
  endtask
  task t_idle;
    tick(40);
    chk(bcd_data_o, 24'h0);
    chk({23'h0, data_valid_o}, 24'h0);
    $display("idle done");
  endtask
  task t_single;
    feed(24'h123456);
    req(8'd3);
    until_v(1);
    until_v(0);
    chk(24'(n), 24'd12);
    // the controller latches one edge after valid rises, so look once valid has gone
    chk(got, 24'h123456);
    n = 0;
    while (bcd_data_o !== 24'h0 && n < 50) begin
      tick(1);
      n++;
    end
    chk(24'(n), 24'd5);
    $display("single done");
  endtask
  task t_cont;
    feed(24'h111111);
    req(8'd200);
    until_v(1);
    feed(24'h222222);
    tick(22);
    chk(bcd_data_o, 24'h222222);
    hold_n_i = 0;
    tick(4); // let the hold pass the sync flops first
    repeat (9) feed(24'h333333);
    chk({23'h0, meas_ready_o}, 24'h0); // full buffer refuses
    tick(25);
    chk(bcd_data_o, 24'h222222);
    chk({23'h0, data_valid_o}, 24'h1);
    hold_n_i = 1;
    until_v(0);
    // once hold lifts, the backed-up words drain and a later refresh shows them
    chk(bcd_data_o, 24'h333333);
    $display("continuous done");
  endtask
  initial begin
    tick(6);
    reset_n_i = 1;
    t_idle;
    t_single;
    t_idle;
    t_cont;
    t_idle;
    report_and_stop;
  end
endmodule // tb_top
